// ==== verilog/uxf_flow_irq.sv ====
// In-band pause/resume flow control and six-source interrupt merge for a UART.
// Assumes the receiver, transmitter and FIFOs are on clk and drive plain levels
// and pulses; the transmitter honours tx_halt only between characters.
//
// How it works
// [RULE1] Global enable off stops all flow control; receive mode picks pair one, two, both.
// [RULE2] A pause match halts transmit after the current character and sets the pause flag.
// [RULE3] After pause, a resume match clears pause flag, its mask, and releases transmit.
// [RULE4] With resume-on-any, any received character other than a pause match resumes and is still stored.
// [RULE5] Matched pause/resume characters are not stored, except special and resume-on-any.
// [RULE6] Parity, framing and break errors never block a character match.
// [RULE7] Transmit insert mode picks off, pair one, pair two or both of each pair.
// [RULE8] Receive level past trigger inserts a pause character and sets remote halted.
// [RULE9] Receive level below trigger after pause inserts resume and clears remote halted.
// [RULE10] Flow control turned off after pause sent inserts resume, clears remote halted.
// [RULE11] Inserted characters go to the transmitter framed like normal data.
// [RULE12] Software reacts to receive irq and polls remote halted before reading.
// [RULE13] Software never enables hardware and software flow control together.
// [RULE14] Special detect: flow off, second pause char sets pause flag, no halt, stored.
// [RULE15] Writing one to the pause clear bit clears the pause flag.
// [RULE16] Six maskable sources merge to one irq; raw and masked status readable.
// [RULE17] A source reaches irq and masked status only when its mask bit is one.
// [RULE18] Transmit-empty flag sets when busy falls.
// [RULE19] FIFO mode: receive flag sets at watermark, clears below it or by clear.
// [RULE20] Without FIFOs, receive flag follows the single location holding data.
// [RULE21] FIFO mode: transmit flag sets below watermark, clears above it or by clear.
// [RULE22] Without FIFOs, transmit flag is edge based: set on emptying, cleared by write or clear.
// [RULE23] The global enable bit sits in the flow control register and gates all flow control except special detect.
// [RULE24] Two-character match needs the second right after the first; else restart.
`timescale 1ns/1ps
`default_nettype none
`include "uxf_defs.svh"

module uxf_flow_irq (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic [4:0]  rx_level,
    input  wire logic [4:0]  tx_level,
    input  wire logic        tx_wr,
    input  wire logic        tx_busy,
    input  wire logic        tx_ins_ready,
    input  wire logic        timeout_evt,
    input  wire logic        error_evt,
    output logic             rx_push,
    output logic      [7:0]  rx_push_data,
    output logic             tx_halt,
    output logic             tx_ins_valid,
    output logic      [7:0]  tx_ins_data,
    output logic             irq
);

    uxf_pkg::uxf_state_t st;
    uxf_pkg::uxf_state_t next_st;

    logic       soft_flow_global_en;
    logic       special_char_detect_en;
    logic       resume_on_any_char;
    logic       fifo_en;
    logic [1:0] rx_match_mode;
    logic [1:0] tx_insert_mode;
    logic       flow_on;
    logic       pause_hit;
    logic       resume_hit;
    logic       special_hit;
    logic       resume_any;
    logic       resume_go;
    logic       acc;
    logic       wr_acc;
    logic [5:0] sw_clear;
    logic [5:0] set_raw;
    logic [5:0] clr_raw;
    logic [4:0] rx_trig_eff;
    logic [4:0] tx_wm_eff;
    logic       tx_flow_on;
    logic       want_pause;
    logic       want_resume;

    // -------------------------------------------------------------------------
    // Control field views
    // -------------------------------------------------------------------------
    assign soft_flow_global_en    = st.ctrl[`UXF_CTL_EN];
    assign special_char_detect_en = st.ctrl[`UXF_CTL_SPEC];
    assign resume_on_any_char     = st.ctrl[`UXF_CTL_ANY];
    assign fifo_en                = st.ctrl[`UXF_CTL_FIFO];
    assign rx_match_mode          = st.ctrl[`UXF_CTL_RXM_LO +: 2];
    assign tx_insert_mode         = st.ctrl[`UXF_CTL_TXM_LO +: 2];
    // Special detect turns flow control off
    assign flow_on    = soft_flow_global_en && !special_char_detect_en; // RULE1 RULE23 RULE14
    assign tx_flow_on = flow_on && (tx_insert_mode != `UXF_MODE_OFF); // RULE7

    // -------------------------------------------------------------------------
    // Character selection for a pair mode and step
    // -------------------------------------------------------------------------
    function automatic logic [7:0] pick_char(input logic [1:0] mode,
                                             input logic       step2,
                                             input logic [7:0] c1,
                                             input logic [7:0] c2);
        logic [7:0] r;
        r = c1;
        if (mode == `UXF_MODE_SECOND || step2) begin
            r = c2;
        end
        return r;
    endfunction

    // -------------------------------------------------------------------------
    // Receive matchers; rx_data compared regardless of error status
    // -------------------------------------------------------------------------
    uxf_char_match u_pause_match (
        .clk        (clk),
        .rst_n      (rst_n),
        .enable     (flow_on),
        .char_valid (rx_valid),
        .char_in    (rx_data),
        .mode       (rx_match_mode),
        .first      (st.pau1),
        .second     (st.pau2),
        .hit        (pause_hit)
    ); // RULE1 RULE6

    uxf_char_match u_resume_match (
        .clk        (clk),
        .rst_n      (rst_n),
        .enable     (flow_on && st.tx_halt),
        .char_valid (rx_valid),
        .char_in    (rx_data),
        .mode       (rx_match_mode),
        .first      (st.res1),
        .second     (st.res2),
        .hit        (resume_hit)
    ); // RULE3 RULE6

    // Special character and resume-any terms
    assign special_hit = special_char_detect_en && rx_valid && (rx_data == st.pau2); // RULE14 RULE6
    assign resume_any  = flow_on && st.tx_halt && resume_on_any_char && rx_valid; // RULE4
    assign resume_go   = st.tx_halt && (resume_hit || resume_any) && !pause_hit; // RULE3

    // Bus strobes: an access completes on the cycle waitrequest is low
    assign acc      = (avs_read || avs_write) && !st.waitreq;
    assign wr_acc   = acc && avs_write;
    assign sw_clear = (wr_acc && avs_address == `UXF_OFF_CLEAR) ? avs_writedata[5:0] : 6'h00;

    // Watermarks collapse to one location without FIFOs
    assign rx_trig_eff = fifo_en ? st.rx_trig : 5'h01; // RULE19 RULE20
    assign tx_wm_eff   = fifo_en ? st.tx_wm : 5'h01; // RULE21 RULE22

    // Insertion wishes
    assign want_pause  = tx_flow_on && !st.remote_halted && (rx_level >= st.rx_trig); // RULE8
    assign want_resume = st.remote_halted && (!tx_flow_on || rx_level < st.rx_trig); // RULE9 RULE10

    // -------------------------------------------------------------------------
    // Interrupt set and clear terms; set wins over clear
    // -------------------------------------------------------------------------
    always_comb begin
        set_raw = 6'h00;
        clr_raw = sw_clear; // RULE15
        set_raw[`UXF_IRQ_TXE]   = st.busy_q && !tx_busy; // RULE18
        set_raw[`UXF_IRQ_PAUSE] = pause_hit || special_hit; // RULE2 RULE14
        clr_raw[`UXF_IRQ_PAUSE] = sw_clear[`UXF_IRQ_PAUSE] || resume_go; // RULE3 RULE15
        set_raw[`UXF_IRQ_RX]    = (st.rx_level_q < rx_trig_eff) && (rx_level >= rx_trig_eff); // RULE19 RULE20
        clr_raw[`UXF_IRQ_RX]    = sw_clear[`UXF_IRQ_RX] || (rx_level < rx_trig_eff); // RULE19 RULE20
        set_raw[`UXF_IRQ_TX]    = (st.tx_level_q >= tx_wm_eff) && (tx_level < tx_wm_eff); // RULE21 RULE22
        clr_raw[`UXF_IRQ_TX]    = sw_clear[`UXF_IRQ_TX]
                                  || (fifo_en ? (tx_level > st.tx_wm) : tx_wr); // RULE21 RULE22
        set_raw[`UXF_IRQ_TMO]   = timeout_evt;
        set_raw[`UXF_IRQ_ERR]   = error_evt;
    end

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Bus handshake: one wait cycle, then the answer
        next_st.waitreq = !((avs_read || avs_write) && st.waitreq);
        if ((avs_read || avs_write) && st.waitreq) begin
            case (avs_address)
                `UXF_OFF_SFCTRL: next_st.rdata = {24'h000000, st.ctrl};
                `UXF_OFF_RES1:   next_st.rdata = {24'h000000, st.res1};
                `UXF_OFF_RES2:   next_st.rdata = {24'h000000, st.res2};
                `UXF_OFF_PAU1:   next_st.rdata = {24'h000000, st.pau1};
                `UXF_OFF_PAU2:   next_st.rdata = {24'h000000, st.pau2};
                `UXF_OFF_LEVEL:  next_st.rdata = {19'h00000, st.tx_wm, 3'h0, st.rx_trig};
                `UXF_OFF_FLAGS:  next_st.rdata = {29'h00000000, tx_busy, st.tx_halt,
                                                  st.remote_halted};
                `UXF_OFF_MASK:   next_st.rdata = {26'h0000000, st.mask};
                `UXF_OFF_RAW:    next_st.rdata = {26'h0000000, st.raw}; // RULE16
                `UXF_OFF_MASKED: next_st.rdata = {26'h0000000, st.raw & st.mask}; // RULE16 RULE17
                default:         next_st.rdata = 32'h00000000;
            endcase
        end
        // Register writes
        if (wr_acc) begin
            case (avs_address)
                `UXF_OFF_SFCTRL: next_st.ctrl = avs_writedata[7:0];
                `UXF_OFF_RES1:   next_st.res1 = avs_writedata[7:0];
                `UXF_OFF_RES2:   next_st.res2 = avs_writedata[7:0];
                `UXF_OFF_PAU1:   next_st.pau1 = avs_writedata[7:0];
                `UXF_OFF_PAU2:   next_st.pau2 = avs_writedata[7:0];
                `UXF_OFF_LEVEL: begin
                    next_st.rx_trig = avs_writedata[`UXF_LVL_RX_LO +: 5];
                    next_st.tx_wm   = avs_writedata[`UXF_LVL_TX_LO +: 5];
                end
                `UXF_OFF_MASK:   next_st.mask = avs_writedata[5:0];
                default:         next_st.ctrl = st.ctrl;
            endcase
        end
        // Resume disables the pause interrupt
        if (resume_go) begin
            next_st.mask[`UXF_IRQ_PAUSE] = 1'b0; // RULE3
        end

        // Local transmit halt
        if (pause_hit) begin
            next_st.tx_halt = 1'b1; // RULE2
        end else if (resume_go || !flow_on) begin
            next_st.tx_halt = 1'b0; // RULE3 RULE1
        end

        // Receive FIFO push, matched flow characters withheld
        next_st.rx_push      = rx_valid && !pause_hit && !(resume_hit && !resume_any); // RULE5 RULE4
        next_st.rx_push_data = rx_data;

        // Raw status and merged interrupt
        next_st.raw = set_raw | (st.raw & ~clr_raw);
        next_st.irq = |(next_st.raw & next_st.mask); // RULE16 RULE17

        // Edge history
        next_st.busy_q     = tx_busy;
        next_st.rx_level_q = rx_level;
        next_st.tx_level_q = tx_level;

        // Pause/resume insertion sequencer
        case (st.ins_state)
            uxf_pkg::UXF_INS_IDLE: begin
                if (want_pause) begin
                    next_st.ins_state = uxf_pkg::UXF_INS_FIRST;
                    next_st.ins_pause = 1'b1;
                    next_st.ins_mode  = tx_insert_mode; // RULE7
                    next_st.ins_valid = 1'b1;
                    next_st.ins_data  = pick_char(tx_insert_mode, 1'b0, st.pau1, st.pau2); // RULE8
                end else if (want_resume) begin
                    next_st.ins_state = uxf_pkg::UXF_INS_FIRST;
                    next_st.ins_pause = 1'b0;
                    next_st.ins_valid = 1'b1;
                    next_st.ins_data  = pick_char(st.ins_mode, 1'b0, st.res1, st.res2); // RULE9 RULE10
                end
            end
            uxf_pkg::UXF_INS_FIRST: begin
                if (tx_ins_ready) begin
                    if (st.ins_mode == `UXF_MODE_BOTH) begin
                        next_st.ins_state = uxf_pkg::UXF_INS_SECOND;
                        next_st.ins_data  = st.ins_pause ? st.pau2 : st.res2;
                    end else begin
                        next_st.ins_state     = uxf_pkg::UXF_INS_IDLE;
                        next_st.ins_valid     = 1'b0;
                        next_st.remote_halted = st.ins_pause; // RULE8 RULE9
                    end
                end
            end
            uxf_pkg::UXF_INS_SECOND: begin
                if (tx_ins_ready) begin
                    next_st.ins_state     = uxf_pkg::UXF_INS_IDLE;
                    next_st.ins_valid     = 1'b0;
                    next_st.remote_halted = st.ins_pause; // RULE8 RULE9 RULE10
                end
            end
            default: begin
                next_st.ins_state = uxf_pkg::UXF_INS_IDLE;
                next_st.ins_valid = 1'b0;
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st           <= '0;
            st.waitreq   <= 1'b1;
            st.ctrl      <= `UXF_RST_CTRL;
            st.rx_trig   <= `UXF_RST_RXTRIG;
            st.tx_wm     <= `UXF_RST_TXWM;
            st.ins_state <= uxf_pkg::UXF_INS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign avs_readdata    = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign rx_push         = st.rx_push;
    assign rx_push_data    = st.rx_push_data;
    assign tx_halt         = st.tx_halt;
    assign tx_ins_valid    = st.ins_valid; // RULE11
    assign tx_ins_data     = st.ins_data;
    assign irq             = st.irq;

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_pause_in;
        pause_hit;
    endsequence

    sequence s_halted_after;
        tx_halt && st.raw[`UXF_IRQ_PAUSE];
    endsequence

    a_pause_halts: assert property (s_pause_in |=> s_halted_after) // RULE2
        else $error("pause match did not halt and flag");

    a_resume_releases: assert property (resume_go && !(wr_acc && avs_address == `UXF_OFF_MASK)
        |=> !tx_halt && !st.raw[`UXF_IRQ_PAUSE] && !st.mask[`UXF_IRQ_PAUSE]) // RULE3
        else $error("resume did not release transmit");

    a_match_not_stored: assert property (pause_hit |=> !rx_push) // RULE5
        else $error("matched pause character was stored");

    a_any_stored: assert property (resume_any && !pause_hit |=> rx_push && !tx_halt) // RULE4
        else $error("resume-any character lost or no resume");

    a_special_kept: assert property (special_hit
        |=> rx_push && st.raw[`UXF_IRQ_PAUSE] && !tx_halt) // RULE14
        else $error("special character handling wrong");

    a_irq_masked: assert property (##1 irq == |($past(next_st.raw) & st.mask)) // RULE17
        else $error("irq does not follow masked status");

    a_busy_fall: assert property ($fell(tx_busy) |=> st.raw[`UXF_IRQ_TXE]) // RULE18
        else $error("busy fall missed transmit empty");

    a_ins_hold: assert property (tx_ins_valid && !tx_ins_ready
        |=> tx_ins_valid && $stable(tx_ins_data)) // RULE11
        else $error("inserted character dropped");

    a_halted_cause: assert property ($rose(st.remote_halted)
        |-> $past(tx_ins_valid && tx_ins_ready && st.ins_pause)) // RULE8
        else $error("remote halted without pause sent");

    a_resume_off: assert property (st.remote_halted && !tx_flow_on
        && st.ins_state == uxf_pkg::UXF_INS_IDLE |=> tx_ins_valid) // RULE10
        else $error("no resume after flow off");

endmodule
`default_nettype wire

// ==== verilog/uxf_defs.svh ====
// Register offsets, field positions and reset values for the flow/irq block.
// Assumes byte addressing on a 32-bit Avalon-MM slave, one register per word.
`ifndef UXF_DEFS_SVH
`define UXF_DEFS_SVH

// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define UXF_OFF_SFCTRL   6'h00
`define UXF_OFF_RES1     6'h04
`define UXF_OFF_RES2     6'h08
`define UXF_OFF_PAU1     6'h0c
`define UXF_OFF_PAU2     6'h10
`define UXF_OFF_LEVEL    6'h14
`define UXF_OFF_FLAGS    6'h18
`define UXF_OFF_MASK     6'h1c
`define UXF_OFF_RAW      6'h20
`define UXF_OFF_MASKED   6'h24
`define UXF_OFF_CLEAR    6'h28

// -----------------------------------------------------------------------------
// Flow control register fields
// -----------------------------------------------------------------------------
`define UXF_CTL_EN       0
`define UXF_CTL_RXM_LO   1
`define UXF_CTL_TXM_LO   3
`define UXF_CTL_ANY      5
`define UXF_CTL_SPEC     6
`define UXF_CTL_FIFO     7

// -----------------------------------------------------------------------------
// Level select fields, flag bits, interrupt bits
// -----------------------------------------------------------------------------
`define UXF_LVL_RX_LO    0
`define UXF_LVL_TX_LO    8
`define UXF_FLG_REMOTE   0
`define UXF_FLG_HALT     1
`define UXF_FLG_BUSY     2
`define UXF_IRQ_TXE      0
`define UXF_IRQ_PAUSE    1
`define UXF_IRQ_RX       2
`define UXF_IRQ_TX       3
`define UXF_IRQ_TMO      4
`define UXF_IRQ_ERR      5

// -----------------------------------------------------------------------------
// Reset values and match modes
// -----------------------------------------------------------------------------
`define UXF_RST_CTRL     8'h80
`define UXF_RST_RXTRIG   5'h08
`define UXF_RST_TXWM     5'h08
`define UXF_MODE_OFF     2'h0
`define UXF_MODE_FIRST   2'h1
`define UXF_MODE_SECOND  2'h2
`define UXF_MODE_BOTH    2'h3

`endif

// ==== verilog/uxf_pkg.sv ====
// Types shared by the flow/irq block and its character matcher.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package uxf_pkg;

    // Insertion sequencer states
    typedef enum logic [1:0] {
        UXF_INS_IDLE,
        UXF_INS_FIRST,
        UXF_INS_SECOND
    } uxf_ins_t;

    // Matcher state
    typedef struct packed {
        logic seen_first;
    } uxf_match_t;

    // Top-level state
    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
        logic [7:0]  ctrl;
        logic [7:0]  res1;
        logic [7:0]  res2;
        logic [7:0]  pau1;
        logic [7:0]  pau2;
        logic [4:0]  rx_trig;
        logic [4:0]  tx_wm;
        logic [5:0]  mask;
        logic [5:0]  raw;
        logic        irq;
        logic        tx_halt;
        logic        remote_halted;
        uxf_ins_t    ins_state;
        logic        ins_pause;
        logic [1:0]  ins_mode;
        logic        ins_valid;
        logic [7:0]  ins_data;
        logic        rx_push;
        logic [7:0]  rx_push_data;
        logic        busy_q;
        logic [4:0]  rx_level_q;
        logic [4:0]  tx_level_q;
    } uxf_state_t;

endpackage
`default_nettype wire

// ==== verilog/uxf_char_match.sv ====
// Pause or resume character matcher, one or two characters deep.
// Assumes char_valid is a one-cycle pulse per received character.
`timescale 1ns/1ps
`default_nettype none
`include "uxf_defs.svh"

module uxf_char_match (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       enable,
    input  wire logic       char_valid,
    input  wire logic [7:0] char_in,
    input  wire logic [1:0] mode,
    input  wire logic [7:0] first,
    input  wire logic [7:0] second,
    output logic            hit
);

    uxf_pkg::uxf_match_t st;
    uxf_pkg::uxf_match_t next_st;

    // -------------------------------------------------------------------------
    // Match decode; error status never enters the compare
    // -------------------------------------------------------------------------
    always_comb begin
        next_st = st;
        hit     = 1'b0;
        if (enable && char_valid) begin
            case (mode)
                `UXF_MODE_FIRST:  hit = (char_in == first);
                `UXF_MODE_SECOND: hit = (char_in == second);
                `UXF_MODE_BOTH:   hit = st.seen_first && (char_in == second); // RULE24
                default:          hit = 1'b0;
            endcase
            // Any character other than the first restarts the pair
            next_st.seen_first = (mode == `UXF_MODE_BOTH) && (char_in == first); // RULE24
        end
        if (!enable) begin
            next_st.seen_first = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule
`default_nettype wire

// ==== dv/uxf_remote_model.sv ====
// Far-side serial device: takes inserted flow characters off the transmitter.
// Assumes the flow block's insert handshake on the same clock.
`timescale 1ns/1ps
`default_nettype none
module uxf_remote_model (
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic       tx_ins_valid,
    input  wire logic [7:0] tx_ins_data,
    output logic            tx_ins_ready,
    output logic [7:0]      last_char
);
    logic phase = 1'b0;
    // Ready every cycle, or every other cycle when slow
    assign tx_ins_ready = !slow || phase;
    // Keep the last character that left the line
    always_ff @(posedge clk) begin
        phase <= !phase;
        if (tx_ins_valid && tx_ins_ready) last_char <= tx_ins_data;
    end
endmodule
`default_nettype wire

// ==== dv/test_uxf_flow_irq.sv ====
// Self-checking bench for the flow/irq block.
// Assumes the design's Avalon-MM contract with one wait cycle.
`timescale 1ns/1ps
`default_nettype none
module test_uxf_flow_irq;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, rxv = 1'b0, tmo = 1'b0, err = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic waitreq, push, halt, ivld, irdy, irq;
    logic [7:0] rxd = 8'h00, pdat, idat, last;
    logic [4:0] lvl = 5'h00, txl = 5'h00;
    logic bsy = 1'b0, twr = 1'b0;
    int fail_count = 0, compares = 0;
    always #5 clk = ~clk;
    uxf_flow_irq i_dut (.clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(waitreq),
        .rx_valid(rxv), .rx_data(rxd), .rx_level(lvl), .tx_level(txl), .tx_wr(twr),
        .tx_busy(bsy), .tx_ins_ready(irdy), .timeout_evt(tmo), .error_evt(err),
        .rx_push(push), .rx_push_data(pdat), .tx_halt(halt), .tx_ins_valid(ivld),
        .tx_ins_data(idat), .irq(irq));
    uxf_remote_model i_far (.clk(clk), .slow(1'b1), .tx_ins_valid(ivld),
        .tx_ins_data(idat), .tx_ins_ready(irdy), .last_char(last));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Bus cycle held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        addr <= a; wd <= d; rd <= !w; wr <= w;
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdat;
        rd <= 1'b0; wr <= 1'b0;
        @(posedge clk);
    endtask
    // One received character; push and halt captured one cycle later
    task automatic rx(input logic [7:0] c, input logic ep, input logic eh);
        rxv <= 1'b1; rxd <= c;
        @(posedge clk);
        rxv <= 1'b0; rxd <= ~c;
        #1 chk("push", push, ep);
        chk("push data", pdat, c);
        chk("halt", halt, eh);
        @(posedge clk);
    endtask
    // Wait for an inserted character to be taken by the far side
    task automatic ins(input logic [7:0] e, input logic [31:0] f);
        int n;
        n = 0;
        while (ivld !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        while (ivld === 1'b1 && n < 100) begin @(posedge clk); n++; end
        chk("inserted", last, e);
        bus(1'b0, 6'h18, 0);
        chk("remote_halted", q & 1, f);
    endtask
    task automatic pulse_irq(input logic [31:0] m, input logic ei);
        bus(1'b1, 6'h1c, m);
        tmo <= 1'b1; err <= 1'b1;
        @(posedge clk);
        tmo <= 1'b0; err <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq", irq, ei);
        bus(1'b0, 6'h24, 0);
        chk("masked", q, m & 32'h30);
        bus(1'b1, 6'h28, 32'h30);
        bus(1'b0, 6'h20, 0);
        chk("raw cleared", q & 32'h30, 0);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        tally_and_finish;
    end
    // Reset values, single pair matching and pause/resume insertion
    task automatic flow_basic;
        bus(1'b0, 6'h00, 0);
        chk("ctrl reset", q, 32'h80);
        bus(1'b0, 6'h3c, 0);
        chk("unmapped", q, 0);
        bus(1'b1, 6'h04, 32'h11);
        bus(1'b1, 6'h0c, 32'h13);
        bus(1'b1, 6'h00, 32'h8b);
        rx(8'h13, 1'b0, 1'b1);
        bus(1'b0, 6'h20, 0);
        chk("pause raw", q & 2, 2);
        rx(8'h41, 1'b1, 1'b1);
        rx(8'h11, 1'b0, 1'b0);
        bus(1'b0, 6'h20, 0);
        chk("pause raw clr", q & 2, 0);
        lvl <= 5'h08;
        ins(8'h13, 1);
        lvl <= 5'h02;
        ins(8'h11, 0);
        lvl <= 5'h08;
        ins(8'h13, 1);
        bus(1'b1, 6'h00, 32'h80);
        ins(8'h11, 0);
    endtask
    // Pair matching, resume on any character, special character detect
    task automatic pair_any_special;
        bus(1'b1, 6'h10, 32'h93);
        bus(1'b1, 6'h08, 32'h91);
        bus(1'b1, 6'h00, 32'h87);
        rx(8'h13, 1'b1, 1'b0);
        rx(8'h93, 1'b0, 1'b1);
        rx(8'h11, 1'b1, 1'b1);
        rx(8'h41, 1'b1, 1'b1);
        rx(8'h91, 1'b1, 1'b1);
        bus(1'b1, 6'h00, 32'ha7);
        rx(8'h55, 1'b1, 1'b0);
        bus(1'b1, 6'h00, 32'hc0);
        rx(8'h93, 1'b1, 1'b0);
        bus(1'b0, 6'h20, 0);
        chk("special raw", q & 2, 2);
        bus(1'b1, 6'h28, 32'h2);
        bus(1'b0, 6'h20, 0);
        chk("special clr", q & 2, 0);
    endtask
    // Busy fall and transmit level crossings, with and without FIFOs
    task automatic tx_irq;
        bsy <= 1'b1; txl <= 5'h09;
        repeat (2) @(posedge clk);
        bsy <= 1'b0; txl <= 5'h03;
        repeat (2) @(posedge clk);
        bus(1'b0, 6'h20, 0);
        chk("txe and tx set", q & 32'h9, 32'h9);
        txl <= 5'h09;
        @(posedge clk);
        bus(1'b0, 6'h20, 0);
        chk("tx level clr", q & 32'h8, 0);
        bus(1'b1, 6'h00, 32'h00);
        txl <= 5'h00;
        @(posedge clk);
        bus(1'b0, 6'h20, 0);
        chk("tx one empty", q & 32'h8, 32'h8);
        twr <= 1'b1;
        @(posedge clk);
        twr <= 1'b0;
        bus(1'b0, 6'h20, 0);
        chk("tx write clr", q & 32'h8, 0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        flow_basic;
        pair_any_special;
        tx_irq;
        pulse_irq(32'h10, 1'b1);
        pulse_irq(32'h00, 1'b0);
        tally_and_finish;
    end
endmodule
`default_nettype wire
